// ==== rtl/quad_dac_ctrl.sv ====
/*
  Top of the four-channel converter control. Samples the serial link pins,
  decodes command words into double-buffered channel latches, drives the
  scaled channel levels and exposes control and state over an APB slave.
  Assumes clk at 250 MHz, far faster than the serial clock, so every link
  edge is seen as a level change of the synchronised pins.
  Link edges reach the latches about three clocks after the pins move and
  the levels one clock after that; a host must keep every pin level for
  at least two clocks or the change may be missed.
*/
`timescale 1ns/10ps
`default_nettype none
`include "quad_dac_defs.svh"
module quad_dac_ctrl #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic      [ADDR_W-1:0]     paddr,
  input  wire logic      [31:0]           pwdata,
  output logic           [31:0]           prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Serial link pins
  input  wire quad_dac_pkg::serial_pins_t link_pins,
  // Scaled channel levels
  output var quad_dac_pkg::level_t        channel_a_output,
  output var quad_dac_pkg::level_t        channel_b_output,
  output var quad_dac_pkg::level_t        channel_c_output,
  output var quad_dac_pkg::level_t        channel_d_output
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  localparam int NCH = 4;

  typedef struct packed {
    quad_dac_pkg::chan_t  [NCH-1:0] in_q;   // Input latches.
    quad_dac_pkg::chan_t  [NCH-1:0] out_q;  // Output latches.
    quad_dac_pkg::level_t [NCH-1:0] level;  // Scaled levels.
    logic [NCH-1:0]                 pend;   // Input newer than output.
    logic                           link_en;
    logic                           sclk_prev;
    logic                           latch_prev;
    logic                           upd_prev;
    logic [15:0]                    words;  // Words latched so far.
    logic [31:0]                    prdata;
    logic                           pready;
    logic                           pslverr;
  } ctrl_state_t;

  ctrl_state_t st_r;   // Registered state.
  ctrl_state_t st_nxt; // Next state.

  // ------------------------------------------------------------------
  // Pin synchronisation and edges
  // ------------------------------------------------------------------
  quad_dac_pkg::serial_pins_t pins_s; // Synchronised pin levels.

  // All four pins pass two flip-flops before anything reads them.
  pin_sync #(
    .W ($bits(quad_dac_pkg::serial_pins_t))
  ) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (link_pins),
    .sync_out (pins_s)
  );

  logic sclk_fall;  // Serial clock fell.
  logic latch_fall; // Latch strobe fell.
  logic upd_fall;   // Update strobe fell.

  // Edges compare the synchronised level with last cycle's copy.
  assign sclk_fall  = st_r.sclk_prev  & ~pins_s.sclk;
  assign latch_fall = st_r.latch_prev & ~pins_s.latch_strobe & st_r.link_en;
  assign upd_fall   = st_r.upd_prev   & ~pins_s.output_update_strobe;

  // ------------------------------------------------------------------
  // Serial input register
  // ------------------------------------------------------------------
  logic [`QD_WORD_BITS-1:0] word;      // Last eleven bits shifted.
  logic [3:0]               bit_count; // Bits since last latch.
  logic                     shift_en;  // Shift strobe.

  // Bits count only while the latch strobe idles high and the link is on.
  assign shift_en = sclk_fall & pins_s.latch_strobe & st_r.link_en;

  serial_shifter #(
    .WORD_W (`QD_WORD_BITS)
  ) u_shift (
    .clk    (clk),
    .rstn   (rstn),
    .sample (shift_en),
    .bit_in (pins_s.sdata),
    .clear  (latch_fall),
    .word   (word),
    .count  (bit_count)
  );

  // ------------------------------------------------------------------
  // Command word fields
  // ------------------------------------------------------------------
  logic [1:0]          sel;      // Target channel index.
  quad_dac_pkg::chan_t new_chan; // Gain and code from the word.

  // Select bits map straight onto the index, 00 for A up to 11 for D.
  assign sel           = {word[`QD_SEL_HI_POS], word[`QD_SEL_LO_POS]};
  assign new_chan.gain = word[`QD_GAIN_POS];
  assign new_chan.code = word[`QD_CODE_MSB:`QD_CODE_LSB];

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  logic              setup;    // Setup phase of a transfer.
  logic              wr_take;  // Write takes effect this edge.
  logic              ch_hit;   // Address is one of the channel words.
  logic [1:0]        ch_idx;   // Channel word index.
  logic              mapped;   // Address decodes.
  logic [31:0]       rd_word;  // Read data for the decoded register.
  logic              apply_sw; // Software apply request.

  // Writes to read-only registers are dropped without an error; only an
  // address that decodes to nothing raises pslverr.
  assign setup   = psel & ~penable;
  assign wr_take = psel & penable & st_r.pready & pwrite & ~st_r.pslverr;
  assign ch_hit  = (paddr & ~ADDR_W'(`QD_CH_IDX_MASK)) == ADDR_W'(`QD_OFF_CH0);
  assign ch_idx  = paddr[3:2];
  assign apply_sw = wr_take & (paddr == ADDR_W'(`QD_OFF_CTRL))
                  & pwdata[`QD_CTRL_APPLY];

  // Read mux; unmapped addresses read zero and raise the error flag.
  always_comb begin
    rd_word = 32'h0000_0000;
    mapped  = 1'b1;
    if (ch_hit) begin
      rd_word[`QD_CH_OUT_LSB +: 9] = st_r.out_q[ch_idx];
      rd_word[`QD_CH_IN_LSB +: 9]  = st_r.in_q[ch_idx];
      rd_word[`QD_CH_PEND_POS]     = st_r.pend[ch_idx];
    end else if (paddr == ADDR_W'(`QD_OFF_CTRL)) begin
      rd_word[`QD_CTRL_LINK_EN] = st_r.link_en;
    end else if (paddr == ADDR_W'(`QD_OFF_STATUS)) begin
      rd_word[`QD_ST_COUNT_LSB +: 4]            = bit_count;
      rd_word[`QD_ST_WORD_LSB +: `QD_WORD_BITS] = word;
      rd_word[`QD_ST_UPD_POS]                   = pins_s.output_update_strobe;
      rd_word[`QD_ST_LATCH_POS]                 = pins_s.latch_strobe;
    end else if (paddr == ADDR_W'(`QD_OFF_WORDS)) begin
      rd_word[15:0] = st_r.words;
    end else begin
      mapped = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Per-channel level scaling
  // ------------------------------------------------------------------
  quad_dac_pkg::level_t [NCH-1:0] level_nxt; // Levels next edge.

  // Gain one doubles the level, which is a shift left by one place.
  // Levels are scaled from the registered output latches, so they trail
  // the latches by one edge; this keeps the next-state logic free of a
  // loop through its own result, at the cost of one clock of latency.
  for (genvar ch = 0; ch < NCH; ch++) begin : g_level
    assign level_nxt[ch] = st_r.out_q[ch].gain
                         ? {st_r.out_q[ch].code, 1'b0}
                         : {1'b0, st_r.out_q[ch].code};
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  // The latch is handled before the update edge so that a word latched
  // in the same cycle as the update strobe falls is applied with the rest.
  always_comb begin
    st_nxt            = st_r;
    st_nxt.sclk_prev  = pins_s.sclk;
    st_nxt.latch_prev = pins_s.latch_strobe;
    st_nxt.upd_prev   = pins_s.output_update_strobe;

    // A completed word goes to the selected channel's input latch.
    if (latch_fall) begin
      st_nxt.in_q[sel] = new_chan;
      st_nxt.words     = st_r.words + 16'h0001;
      if (!pins_s.output_update_strobe) begin
        st_nxt.out_q[sel] = new_chan;
      end else begin
        // Strobe high: the output holds, the value waits as pending.
        st_nxt.pend[sel] = 1'b1;
      end
    end

    // Update edge or software apply moves every input latch at once.
    if (upd_fall || apply_sw) begin
      st_nxt.out_q = st_nxt.in_q;
      st_nxt.pend  = '0;
    end

    // Software control register. Turning the link off gates the serial
    // clock and latch strobe only; the update strobe keeps working so a
    // host can still apply values that are already pending.
    if (wr_take && paddr == ADDR_W'(`QD_OFF_CTRL)) begin
      st_nxt.link_en = pwdata[`QD_CTRL_LINK_EN];
    end

    // Answer one cycle after setup so pready comes from a flip-flop.
    st_nxt.pready  = setup;
    st_nxt.pslverr = setup & ~mapped;
    st_nxt.prdata  = setup ? rd_word : st_r.prdata;

    st_nxt.level = level_nxt;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  // Reset stands in for power-on clear: all codes and gains go to zero.
  // Only constants appear here so the asynchronous path stays clean.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int ch = 0; ch < NCH; ch++) begin
        st_r.in_q[ch].code  <= `QD_CODE_RESET;
        st_r.in_q[ch].gain  <= `QD_GAIN_RESET;
        st_r.out_q[ch].code <= `QD_CODE_RESET;
        st_r.out_q[ch].gain <= `QD_GAIN_RESET;
        st_r.level[ch]      <= 9'h000;
      end
      st_r.pend       <= '0;
      st_r.link_en    <= `QD_LINK_EN_RESET;
      st_r.sclk_prev  <= 1'b0;
      st_r.latch_prev <= 1'b0;
      st_r.upd_prev   <= 1'b0;
      st_r.words      <= 16'h0000;
      st_r.prdata     <= 32'h0000_0000;
      st_r.pready     <= 1'b0;
      st_r.pslverr    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Every output is a field of the state register.
  assign prdata           = st_r.prdata;
  assign pready           = st_r.pready;
  assign pslverr          = st_r.pslverr;
  assign channel_a_output = st_r.level[0];
  assign channel_b_output = st_r.level[1];
  assign channel_c_output = st_r.level[2];
  assign channel_d_output = st_r.level[3];

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // Strobe held high and no apply: outputs do not move.
  a_hold_outputs: assert property (
    @(posedge clk) disable iff (!rstn)
    (pins_s.output_update_strobe && st_r.upd_prev && !apply_sw)
      |=> (st_r.out_q == $past(st_r.out_q)))
    else $error("Output latch changed while update strobe high.");

  // Update edge: all outputs equal the inputs one edge later.
  a_update_all: assert property (
    @(posedge clk) disable iff (!rstn)
    upd_fall |=> (st_r.out_q == st_r.in_q) && (st_r.pend == '0))
    else $error("Update edge did not copy all input latches.");

  // Direct load with strobe low reaches the selected output.
  a_direct_load: assert property (
    @(posedge clk) disable iff (!rstn)
    (latch_fall && !pins_s.output_update_strobe)
      |=> (st_r.out_q[$past(sel)] == $past(new_chan)))
    else $error("Direct load missed the selected output.");

  // Select bits steer the word to the named input latch.
  a_select_decode: assert property (
    @(posedge clk) disable iff (!rstn)
    latch_fall |=> (st_r.in_q[$past(sel)] == $past(new_chan)))
    else $error("Word stored in the wrong channel.");

  // A word latched under a high strobe is marked pending.
  a_pending_mark: assert property (
    @(posedge clk) disable iff (!rstn)
    (latch_fall && pins_s.output_update_strobe && !upd_fall && !apply_sw)
      |=> st_r.pend[$past(sel)])
    else $error("Held word not marked pending.");

  // Level follows the output latch with gain scaling, two edges on.
  a_level_scale: assert property (
    @(posedge clk) disable iff (!rstn)
    (latch_fall && !pins_s.output_update_strobe && new_chan.gain)
      |=> ##1 (st_r.level[$past(sel, 2)] == {$past(new_chan.code, 2), 1'b0}))
    else $error("Doubled level wrong after load.");

  // Every setup phase is answered at the next edge.
  a_apb_answer: assert property (
    @(posedge clk) disable iff (!rstn)
    setup |=> pready ##1 !pready)
    else $error("APB answer not one cycle after setup.");

  // Unity gain: the level is the bare code, two edges after the latch.
  a_level_unity: assert property (
    @(posedge clk) disable iff (!rstn)
    (latch_fall && !pins_s.output_update_strobe && !new_chan.gain)
      |=> ##1 (st_r.level[$past(sel, 2)] == {1'b0, $past(new_chan.code, 2)}))
    else $error("Unity level wrong after load.");

  // A latch restarts the bit count for the next word.
  a_count_clear: assert property (
    @(posedge clk) disable iff (!rstn)
    latch_fall |=> (bit_count == 4'h0))
    else $error("Bit count not cleared by the latch.");

  // Every latched word bumps the word counter by one.
  a_words_count: assert property (
    @(posedge clk) disable iff (!rstn)
    latch_fall |=> (st_r.words == ($past(st_r.words) + 16'h0001)))
    else $error("Word counter missed a latch.");

  // Software apply copies every input latch, like the update edge.
  a_apply_soft: assert property (
    @(posedge clk) disable iff (!rstn)
    apply_sw |=> (st_r.out_q == st_r.in_q) && (st_r.pend == '0))
    else $error("Software apply did not copy the input latches.");

  // An address that decodes to nothing answers with an error and zero data.
  a_unmapped_err: assert property (
    @(posedge clk) disable iff (!rstn)
    (setup && !mapped) |=> pslverr && (prdata == 32'h0000_0000))
    else $error("Unmapped address not refused.");

  // A control write sets the link enable from write data bit zero.
  a_ctrl_write: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr_take && (paddr == ADDR_W'(`QD_OFF_CTRL)))
      |=> (st_r.link_en == $past(pwdata[`QD_CTRL_LINK_EN])))
    else $error("Control write did not set the link enable.");
endmodule
`default_nettype wire

// ==== rtl/quad_dac_defs.svh ====
/*
  Constants of the four-channel serial-load converter control: command word
  layout, APB register offsets, field positions and reset values.
  Assumes it is included by its bare name from every file that needs a figure.
*/
`ifndef QUAD_DAC_DEFS_SVH
`define QUAD_DAC_DEFS_SVH

// ------------------------------------------------------------------
// Command word layout
// ------------------------------------------------------------------
`define QD_WORD_BITS      11
`define QD_SEL_HI_POS     10
`define QD_SEL_LO_POS     9
`define QD_GAIN_POS       8
`define QD_CODE_MSB       7
`define QD_CODE_LSB       0

// ------------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------------
`define QD_OFF_CTRL       12'h000
`define QD_OFF_STATUS     12'h004
`define QD_OFF_WORDS      12'h008
`define QD_OFF_CH0        12'h010
`define QD_CH_IDX_MASK    12'h00c

// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define QD_CTRL_LINK_EN   0
`define QD_CTRL_APPLY     1
`define QD_LINK_EN_RESET  1'b1
`define QD_ST_COUNT_LSB   0
`define QD_ST_WORD_LSB    4
`define QD_ST_UPD_POS     16
`define QD_ST_LATCH_POS   17
`define QD_CH_OUT_LSB     0
`define QD_CH_IN_LSB      16
`define QD_CH_PEND_POS    31
`define QD_CODE_RESET     8'h00
`define QD_GAIN_RESET     1'b0
`endif

// ==== rtl/quad_dac_pkg.sv ====
/*
  Types shared by the converter control: one channel setting, the scaled
  output level and the bundle of serial link pins.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package quad_dac_pkg;
  // One channel setting: gain bit above the eight code bits.
  typedef struct packed {
    logic       gain;
    logic [7:0] code;
  } chan_t;

  // Output level in units of one 256th of the reference.
  typedef logic [8:0] level_t;

  // The four serial link pins, as they arrive from the host.
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic latch_strobe;
    logic output_update_strobe;
  } serial_pins_t;
endpackage

// ==== rtl/pin_sync.sv ====
/*
  Two-stage synchroniser for a group of pins from outside the clock domain.
  Assumes the pins change slowly against clk; only stage two is exposed.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Pins in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  // Stage one is read by stage two and nothing else.
  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } sync_state_t;

  sync_state_t st_r;   // Registered stages.
  sync_state_t st_nxt; // Next stages.

  // Advance both stages every clock.
  always_comb begin
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
  end

  // Registers clear to zero so no false falling edge follows reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.s2;
endmodule
`default_nettype wire

// ==== rtl/serial_shifter.sv ====
/*
  Serial input register: shifts one sampled data bit in per falling serial
  clock edge and counts bits up to one word.
  Assumes sample is a one-cycle pulse from the synchronised clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
`include "quad_dac_defs.svh"
module serial_shifter #(
  parameter int WORD_W = `QD_WORD_BITS
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Bit strobe and data
  input  wire logic              sample,
  input  wire logic              bit_in,
  input  wire logic              clear,
  // Word and bit count
  output logic      [WORD_W-1:0] word,
  output logic      [3:0]        count
);
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic [3:0]        count;
  } shift_state_t;

  shift_state_t st_r;   // Registered shift state.
  shift_state_t st_nxt; // Next shift state.

  // Shift left so the first bit sent ends up on top.
  always_comb begin
    st_nxt = st_r;
    if (sample) begin
      st_nxt.word = {st_r.word[WORD_W-2:0], bit_in};
      if (st_r.count != 4'(WORD_W)) begin
        st_nxt.count = st_r.count + 4'h1;
      end
    end
    if (clear) begin
      st_nxt.count = 4'h0;
    end
  end

  // Shift state clears at reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign word  = st_r.word;
  assign count = st_r.count;

  // Each strobe lands the sampled bit at the bottom.
  a_shift_bit_in: assert property (
    @(posedge clk) disable iff (!rstn)
    sample |=> (word[0] == $past(bit_in)) && (word[WORD_W-1:1] == $past(word[WORD_W-2:0])))
    else $error("Sampled bit not shifted in.");

  // Without a strobe the word stays put.
  a_word_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    !sample |=> $stable(word))
    else $error("Shift word changed without a strobe.");
endmodule
`default_nettype wire

// ==== dv/serial_host.sv ====
/*
  Behavioural host on the far side of the serial link. It shifts command
  words MSB first, pulses the latch strobe and sets the update strobe level.
  Assumes the caller invokes its tasks right after a rising edge of clk.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_host (
  // Bench clock
  input  wire logic                      clk,
  // Link pins towards the block
  output var quad_dac_pkg::serial_pins_t pins
);
  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  // Half a 32 ns link period at a 4 ns clk.
  localparam int HALF = 4;

  // The link clock stands low between frames; the latch strobe idles high.
  initial begin
    pins = '{sclk: 1'b0, sdata: 1'b0, latch_strobe: 1'b1, output_update_strobe: 1'b0};
  end

  // Waits a number of rising clk edges.
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Shifts one 11-bit word, then pulses the latch strobe low.
  task automatic send_word(input logic [10:0] w);
    wait_clk(1);
    for (int i = 10; i >= 0; i--) begin
      pins.sdata <= w[i];
      pins.sclk  <= 1'b1;
      wait_clk(HALF);
      pins.sclk  <= 1'b0;
      wait_clk(HALF);
    end
    // Once the hold time is over the data line no longer shows the last bit.
    pins.sdata        <= ~w[0];
    pins.latch_strobe <= 1'b0;
    wait_clk(HALF);
    pins.latch_strobe <= 1'b1;
    wait_clk(HALF);
  endtask

  // Sets the update strobe level; a fall applies all pending values.
  task automatic set_update(input logic v);
    wait_clk(1);
    pins.output_update_strobe <= v;
    wait_clk(2 * HALF);
  endtask
endmodule
`default_nettype wire

// ==== dv/quad_dac_serial_load_control_tb_top.sv ====
/*
  Self-checking bench of the converter control: APB register tasks, a host
  model on the serial link and sequences with expected levels.
  Assumes the design's package and constants header are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "quad_dac_defs.svh"
module quad_dac_serial_load_control_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                       clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]                paddr;
  logic [31:0]                pwdata, prdata;
  quad_dac_pkg::serial_pins_t link_pins;
  quad_dac_pkg::level_t       out_a, out_b, out_c, out_d;
  quad_dac_pkg::level_t       exp_lvl [4]; // Levels the outputs must show.
  quad_dac_pkg::level_t       pend [4];    // Levels waiting for an apply.
  int                         mode;        // 0 direct, 1 held, 2 link off.
  int                         mismatches, compares, cycles;
  logic [31:0]                q;
  logic                       e;

  quad_dac_ctrl dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_pins(link_pins),
    .channel_a_output(out_a), .channel_b_output(out_b),
    .channel_c_output(out_c), .channel_d_output(out_d));
  serial_host host (.clk(clk), .pins(link_pins));

  // ----------------------------------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------------------------------
  always #2 clk = ~clk;

  // A hung handshake must not stall the run; about 1100 cycles are needed.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Counts every comparison and reports a difference at once.
  task automatic check(input logic [35:0] seen, input logic [35:0] expv);
    compares++;
    if (seen !== expv) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask

  // ----------------------------------------------------------------
  // APB master: setup, then access held until pready is sampled high
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads one register and compares it.
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] expv);
    apb(1'b0, a, 32'h0000_0000);
    check({4'h0, q}, {4'h0, expv});
  endtask

  // Compares all four channel levels at once.
  task automatic chk_outs();
    check({out_d, out_c, out_b, out_a}, {exp_lvl[3], exp_lvl[2], exp_lvl[1], exp_lvl[0]});
  endtask

  // Sends one word and tracks where its level should land.
  task automatic load(input int ch, input logic g, input logic [7:0] c);
    quad_dac_pkg::level_t v;
    v = g ? {c, 1'b0} : {1'b0, c};
    host.send_word({ch[1:0], g, c});
    if (mode != 2) pend[ch] = v;
    if (mode == 0) exp_lvl[ch] = v;
    chk_outs();
  endtask

  // Copies every pending level to the outputs.
  task automatic apply_all();
    for (int i = 0; i < 4; i++) exp_lvl[i] = pend[i];
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    mode = 0;
    for (int i = 0; i < 4; i++) begin
      exp_lvl[i] = 9'h000;
      pend[i] = 9'h000;
    end
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    // Power-up state: every channel at code zero, link enabled.
    chk_outs();
    rd_chk(`QD_OFF_CTRL, 32'h0000_0001);
    for (int i = 0; i < 4; i++) rd_chk(12'(`QD_OFF_CH0 + 4 * i), 32'h0000_0000);
    // An unmapped address answers with an error and zero data.
    apb(1'b1, 12'h0f0, 32'hffff_ffff);
    apb(1'b0, 12'h0f0, 32'h0000_0000);
    check({3'h0, e, q}, 36'h1_0000_0000);
    // Direct loads, one per select code, with both gains and edge codes.
    load(0, 1'b0, 8'hff);
    load(1, 1'b1, 8'h81);
    load(2, 1'b1, 8'h01);
    load(3, 1'b0, 8'h80);
    rd_chk(`QD_OFF_STATUS, 32'h0002_6800);
    rd_chk(12'(`QD_OFF_CH0 + 12), 32'h0080_0080);
    rd_chk(`QD_OFF_WORDS, 32'h0000_0004);
    // Update strobe held high: new words stay pending until it falls.
    host.set_update(1'b1);
    mode = 1;
    load(0, 1'b1, 8'h00);
    load(1, 1'b0, 8'h7f);
    load(2, 1'b1, 8'hfe);
    load(3, 1'b1, 8'h55);
    rd_chk(12'(`QD_OFF_CH0 + 4), 32'h807f_0181);
    host.set_update(1'b0);
    apply_all();
    chk_outs();
    rd_chk(12'(`QD_OFF_CH0 + 4), 32'h007f_007f);
    // Software apply while the strobe is high.
    host.set_update(1'b1);
    load(2, 1'b0, 8'h33);
    apb(1'b1, `QD_OFF_CTRL, 32'h0000_0003);
    apply_all();
    repeat (4) @(posedge clk);
    chk_outs();
    rd_chk(`QD_OFF_CTRL, 32'h0000_0001);
    host.set_update(1'b0);
    mode = 0;
    // With the link disabled a full word must change nothing.
    apb(1'b1, `QD_OFF_CTRL, 32'h0000_0000);
    mode = 2;
    load(0, 1'b0, 8'h12);
    apb(1'b1, `QD_OFF_CTRL, 32'h0000_0001);
    mode = 0;
    rd_chk(`QD_OFF_WORDS, 32'h0000_0009);
    // A write to a read-only channel register leaves it unchanged.
    apb(1'b1, `QD_OFF_CH0, 32'hffff_ffff);
    rd_chk(`QD_OFF_CH0, 32'h0100_0100);
    chk_outs();
    results();
  end
endmodule
`default_nettype wire
